// >>> core/tes_ctrl.sv
// trigger selection, exposure timing and strobe output
// assumes pins synchronous to i_clk; i_readout_busy from sensor readout logic
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`default_nettype none
module tes_ctrl
   import tes_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   input  wire logic        i_cc1,
   input  wire logic        i_ext_trig,
   input  wire logic        i_readout_busy,
   output logic             o_strobe,
   output logic             o_exposing,
   output logic             o_readout_start
);
   logic [6:0]        ctrl_r;
   logic [STEP_W-1:0] expo_r;
   logic [31:0]       rdata_r;
   tes_state_t        state_r, state_nxt;
   logic [STEP_W-1:0] left_r, left_nxt;
   logic              trig_d_r;
   logic              strobe_r;
   logic              start_r;

   tes_mode_t mode;
   logic      overlap, src_ext, tpol_high, spol_high, enable;
   logic      trig_raw, trig_act, trig_rise, tick, timed;
   logic      can_start, go, exp_end;

   assign mode      = tes_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
   assign src_ext   = ctrl_r[CTRL_SRC_BIT];
   assign tpol_high = ctrl_r[CTRL_TPOL_BIT];
   assign spol_high = ctrl_r[CTRL_SPOL_BIT];
   assign enable    = ctrl_r[CTRL_EN_BIT];
   assign overlap   = (mode == TES_MODE_FREE) | ctrl_r[CTRL_OVL_BIT];

   assign trig_raw  = src_ext ? i_ext_trig : i_cc1;
   assign trig_act  = tpol_high ? trig_raw : ~trig_raw;
   assign trig_rise = trig_act & ~trig_d_r;
   assign timed     = (mode != TES_MODE_SLAVE);

   // overlapped: expose while previous frame reads out
   assign can_start = enable & (overlap | ~i_readout_busy);
   assign go = can_start & ((mode == TES_MODE_FREE) | trig_rise);
   // slave: exposure follows the trigger width, timer still counts down but does not end it
   assign exp_end = timed ? (tick && left_r == STEP_W'(1)) : ~trig_act;

   tes_step_tick u_tick (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_clear (state_r != TES_ST_EXP),
      .o_tick  (tick)
   );

   always_comb begin
      state_nxt = state_r;
      left_nxt  = left_r;
      case (state_r)
         TES_ST_IDLE: begin
            if (go) begin
               state_nxt = TES_ST_EXP;
               left_nxt  = expo_r;
            end
         end
         TES_ST_EXP: begin
            if (!enable) state_nxt = TES_ST_IDLE;
            else if (exp_end) state_nxt = overlap ? TES_ST_IDLE : TES_ST_READ;
            else if (tick) left_nxt = left_r - 1'b1;
         end
         TES_ST_READ: begin
            if (!i_readout_busy && !start_r) state_nxt = TES_ST_IDLE;
         end
         default: state_nxt = TES_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r  <= TES_ST_IDLE;
         left_r   <= '0;
         trig_d_r <= 1'b0;
         start_r  <= 1'b0;
         strobe_r <= ~CTRL_RST[CTRL_SPOL_BIT];
      end else begin
         state_r  <= state_nxt;
         left_r   <= left_nxt;
         trig_d_r <= trig_act;
         start_r  <= (state_r == TES_ST_EXP) && (state_nxt != TES_ST_EXP) && enable;
         strobe_r <= (state_nxt == TES_ST_EXP) ? spol_high : ~spol_high;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= CTRL_RST;
         expo_r <= EXPO_RST;
      end else if (i_wr) begin
         if (i_addr == ADDR_CTRL) ctrl_r <= i_wdata[6:0];
         if (i_addr == ADDR_EXPO) expo_r <= tes_clamp_steps(i_wdata);
      end
   end

   logic [31:0] rd_mux;
   assign rd_mux = (i_addr == ADDR_CTRL)   ? {25'h0, ctrl_r} :
                   (i_addr == ADDR_EXPO)   ? {15'h0, expo_r} :
                   (i_addr == ADDR_STATUS) ? {10'h0, (state_r == TES_ST_EXP) ? left_r : 17'h0,
                                              trig_act, overlap, state_r} :
                   32'h0;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) rdata_r <= 32'h0;
      else rdata_r <= i_rd ? rd_mux : 32'h0;
   end

   assign o_rdata         = rdata_r;
   assign o_strobe        = strobe_r;
   assign o_exposing      = (state_r == TES_ST_EXP);
   assign o_readout_start = start_r;
endmodule
`default_nettype wire

// >>> core/tes_pkg.sv
// constants, encodings and register map for the trigger / exposure / strobe block
// assumes a single 25 MHz clock and a simple strobed register port
`default_nettype none
package tes_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned STEP_US       = 100;
   localparam int unsigned STEP_CYC      = (STEP_US * (CLK_HZ / 1_000_000));
   localparam int unsigned EXP_MAX_STEPS = 70_000;
   localparam int          STEP_W        = 17;
   localparam int          TICK_W        = 12;

   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_EXPO   = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OVL_BIT  = 2;
   localparam int CTRL_SRC_BIT  = 3;
   localparam int CTRL_TPOL_BIT = 4;
   localparam int CTRL_SPOL_BIT = 5;
   localparam int CTRL_EN_BIT   = 6;

   localparam logic [6:0]        CTRL_RST = 7'h00;
   localparam logic [STEP_W-1:0] EXPO_RST = 17'h00064;

   typedef enum logic [1:0] {
      TES_MODE_FREE   = 2'h0,
      TES_MODE_MASTER = 2'h1,
      TES_MODE_SLAVE  = 2'h2
   } tes_mode_t;

   typedef enum logic [2:0] {
      TES_ST_IDLE = 3'h1,
      TES_ST_EXP  = 3'h2,
      TES_ST_READ = 3'h4
   } tes_state_t;

   function automatic logic [STEP_W-1:0] tes_clamp_steps(input logic [31:0] v);
      if (v == 32'h0) return 17'h00001;
      if (v > EXP_MAX_STEPS) return 17'h11170;
      return v[STEP_W-1:0];
   endfunction
endpackage
`default_nettype wire

// >>> core/tes_step_tick.sv
// 100 us step tick generator
// assumes the 25 MHz system clock
`default_nettype none
module tes_step_tick
   import tes_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_clear,
   output logic      o_tick
);
   logic [TICK_W-1:0] cnt_r;
   logic              wrap;
   assign wrap   = (cnt_r == TICK_W'(STEP_CYC - 1));
   assign o_tick = wrap & ~i_clear;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) cnt_r <= '0;
      else if (i_clear || wrap) cnt_r <= '0;
      else cnt_r <= cnt_r + 1'b1;
   end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the trigger / exposure / strobe block
// assumes the sensor model answers each readout start
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import tes_pkg::*;
   logic        i_clk = 1'h0, i_rst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_cc1 = 1'h0, i_ext_trig = 1'h1;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   wire  [31:0] o_rdata;
   wire         o_strobe, o_exposing, o_readout_start, i_readout_busy;
   int          n_errors = 0, n_checks = 0, seed = 90, e, n;
   always #20 i_clk = ~i_clk;
   tes_ctrl DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_cc1(i_cc1), .i_ext_trig(i_ext_trig), .i_readout_busy(i_readout_busy),
      .o_strobe(o_strobe), .o_exposing(o_exposing), .o_readout_start(o_readout_start));
   tes_sensor_model SENS (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(o_readout_start), .o_busy(i_readout_busy));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= !w;
      @(posedge i_clk);
      i_wr <= 1'h0;
      i_rd <= 1'h0;
      #1 if (!w) chk(o_rdata, d);
      @(posedge i_clk);
   endtask
   task automatic meas(input logic sp, input int x);
      n = 0;
      for (int k = 0; k < 9000 && o_exposing !== 1'h1; k++) begin
         @(posedge i_clk);
         #1;
      end
      chk(o_strobe, sp);
      while (o_exposing === 1'h1 && n < 400000) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk(o_strobe, !sp);
      chk(32'(n - x + 1) <= 32'h2, 32'h1);
      // let sensor readout finish before the next trigger edge
      repeat (40) @(posedge i_clk);
   endtask
   task automatic stop_test;
      if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #2_000_000;
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'h1;
      @(posedge i_clk);
      acc(1'h0, 4'h4, 32'h64);
      acc(1'h0, 4'hC, 32'h0);
      e = 1 + $unsigned($random(seed)) % 3;
      acc(1'h1, 4'h4, e);
      acc(1'h0, 4'h4, e);
      acc(1'h1, 4'h0, 32'h71);
      i_cc1 <= 1'h1;
      meas(1'h1, e * STEP_CYC);
      i_cc1 <= 1'h0;
      acc(1'h1, 4'h0, 32'h4D);
      i_ext_trig <= 1'h0;
      meas(1'h0, e * STEP_CYC);
      i_ext_trig <= 1'h1;
      acc(1'h1, 4'h0, 32'h52);
      i_cc1 <= 1'h1;
      fork
         meas(1'h0, 300);
         begin
            repeat (300) @(posedge i_clk);
            i_cc1 <= 1'h0;
         end
      join
      acc(1'h1, 4'h4, 32'h1);
      acc(1'h1, 4'h0, 32'h60);
      meas(1'h1, STEP_CYC);
      stop_test();
   end
endmodule
`default_nettype wire

// >>> verif/tes_ctrl_monitor.sv
// timing checks on trigger, exposure and strobe ports
// assumes settings are written only between exposures
`default_nettype none
module tes_ctrl_monitor
   import tes_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_cc1,
   input wire logic        i_ext_trig,
   input wire logic        i_readout_busy,
   input wire logic        o_strobe,
   input wire logic        o_exposing,
   input wire logic        o_readout_start
);
   logic [6:0]  ctl_r;
   logic [16:0] exp_r;
   logic        tprev_r;
   logic [31:0] cnt_r;
   wire         tact = (ctl_r[3] ? i_ext_trig : i_cc1) ~^ ctl_r[4];
   wire         slave = ctl_r[1:0] == 2'h2;
   always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n) begin
         ctl_r <= 7'h00;
         exp_r <= 17'h00064;
         tprev_r <= 1'h1;
         cnt_r <= 32'h0;
      end else begin
         if (i_wr && i_addr == 4'h0) ctl_r <= i_wdata[6:0];
         if (i_wr && i_addr == 4'h4) exp_r <= i_wdata[16:0];
         tprev_r <= tact;
         cnt_r <= o_exposing ? cnt_r + 32'h1 : 32'h0;
      end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_strobe_level: assert property ($past(i_rst_n) && $stable(ctl_r[5]) |-> o_strobe == (o_exposing ~^ ctl_r[5]))
      else $error("strobe level wrong");
   a_expo_len: assert property ($fell(o_exposing) && !slave |-> cnt_r + 1 >= exp_r * STEP_CYC && cnt_r <= exp_r * STEP_CYC + 1)
      else $error("exposure length wrong");
   a_trig_start: assert property ($stable(ctl_r) && ctl_r[6] && ctl_r[1:0] == 2'h1 && tact && !tprev_r && !o_exposing
      && !i_readout_busy && !o_readout_start |=> o_exposing)
      else $error("trigger not taken");
   a_slave_end: assert property (slave && o_exposing && !tact |-> ##[1:2] !o_exposing)
      else $error("slave exposure overran");
   a_free_ovl: assert property ($stable(ctl_r) && ctl_r[6] && ctl_r[1:0] == 2'h0 && $fell(o_exposing) |-> ##[0:3] o_exposing)
      else $error("free run stalled");
   a_nonovl_wait: assert property (ctl_r[1:0] != 2'h0 && !ctl_r[2] && i_readout_busy && !o_exposing |=> !o_exposing)
      else $error("exposure during readout");
   a_rdout_end: assert property ($fell(o_exposing) |-> ##[0:1] o_readout_start)
      else $error("no readout start");
endmodule
bind tes_ctrl tes_ctrl_monitor MON (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_cc1, .i_ext_trig,
   .i_readout_busy, .o_strobe, .o_exposing, .o_readout_start);
`default_nettype wire

// >>> verif/tes_sensor_model.sv
// sensor readout model: busy for a while after each start pulse
// assumes a one-cycle start pulse from the block
`default_nettype none
module tes_sensor_model #(parameter int RD_CYC = 20) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_start,
   output logic      o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt_r;
   always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n) cnt_r <= 0;
      else if (i_start) cnt_r <= RD_CYC;
      else if (cnt_r > 0) cnt_r <= cnt_r - 1;
   assign o_busy = cnt_r > 0;
endmodule
`default_nettype wire
